//--- shift_right_pkg.sv
// constants for the shift-right extension unit
package shift_right_pkg;
  localparam logic [7:0] source_off = 8'h00;
  localparam logic [7:0] amount_off = 8'h04;
  localparam logic [7:0] extension_off = 8'h08;
  localparam logic [7:0] exception_off = 8'h0c;
  localparam logic [7:0] instruction_off = 8'h10;
  localparam logic [7:0] target_off = 8'h14;
  localparam logic [7:0] status_off = 8'h18;
  // lsb-numbered positions of the big-endian fields
  localparam int amount_hi = 4;
  localparam int zero_sel_bit = 5;
  localparam int primary_hi = 31;
  localparam int primary_lo = 26;
  localparam int ext_hi = 10;
  localparam int ext_lo = 1;
  localparam int record_pos = 0;
  localparam int so_pos = 0;
  localparam int illegal_pos = 8;
  localparam logic [5:0] primary_op = 6'h1f;
  localparam logic [9:0] ext_rotate_save = 10'h298;
  localparam logic [9:0] ext_shift_word = 10'h218;
  localparam logic [9:0] ext_long_merge = 10'h2d8;
  localparam logic [31:0] reset_word = 32'h0000_0000;
  localparam logic [31:0] all_ones = 32'hffff_ffff;
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  typedef enum {op_none, op_extension, op_word, op_merge} op_t;
endpackage : shift_right_pkg

//--- shift_path_if.sv
// signals between the register core and the rotate/mask unit
`timescale 1ns/1ps
interface shift_path_if;
  logic [31:0] source;
  logic [31:0] amount;
  logic [31:0] extension;
  logic [31:0] rotated;
  logic [31:0] masked;
  logic [31:0] merged;
  modport unit (input source, amount, extension, output rotated, masked, merged);
  modport core (output source, amount, extension, input rotated, masked, merged);
endinterface : shift_path_if

//--- shift_mask_unit.sv
// rotate and mask datapath for the shift-right operations
`timescale 1ns/1ps
module shift_mask_unit (
  shift_path_if.unit path
);
  wire [4:0] n = path.amount[shift_right_pkg::amount_hi:0];
  wire zero_sel = path.amount[shift_right_pkg::zero_sel_bit];
  // rotate left by 32-n equals rotate right by n
  wire [63:0] doubled = {path.source, path.source} >> n;
  wire [31:0] low_ones = shift_right_pkg::all_ones >> n;
  wire [31:0] mask = zero_sel ? 32'h0000_0000 : low_ones;
  assign path.rotated = doubled[31:0];
  assign path.masked = path.rotated & mask;
  // bit 26 set: zero word merged under n ones then zeros
  assign path.merged = zero_sel ? (path.extension & low_ones)
      : ((path.rotated & low_ones) | (path.extension & ~low_ones));
endmodule : shift_mask_unit

//--- shift_right_extension_unit.sv
// axi4-lite register front end and result state of the shift-right unit
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
module shift_right_extension_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic [31:0] source_register;
  logic [31:0] shift_amount_register;
  logic [31:0] extension_register;
  logic [31:0] exception_register;
  logic [31:0] instruction;
  logic [31:0] target_register;
  logic [3:0] cond_field;
  logic illegal;
  logic aw_held;
  logic [7:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  shift_path_if path ();
  shift_mask_unit unit (.path(path));
  assign path.source = source_register;
  assign path.amount = shift_amount_register;
  assign path.extension = extension_register;

  // write path: address and data are taken independently
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  wire commit = aw_held && w_held && !s_axi_bvalid;
  logic [31:0] strobe_mask;
  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    assign strobe_mask[lane*8 +: 8] = {8{w_strb[lane]}};
  end
  wire hit_source = aw_addr == shift_right_pkg::source_off;
  wire hit_amount = aw_addr == shift_right_pkg::amount_off;
  wire hit_extension = aw_addr == shift_right_pkg::extension_off;
  wire hit_exception = aw_addr == shift_right_pkg::exception_off;
  wire hit_instruction = aw_addr == shift_right_pkg::instruction_off;
  wire write_mapped = hit_source || hit_amount || hit_extension || hit_exception
      || hit_instruction || aw_addr == shift_right_pkg::target_off
      || aw_addr == shift_right_pkg::status_off;
  wire [31:0] next_instruction = (instruction & ~strobe_mask) | (w_data & strobe_mask);
  wire [31:0] next_source = (source_register & ~strobe_mask) | (w_data & strobe_mask);
  wire [31:0] next_amount = (shift_amount_register & ~strobe_mask) | (w_data & strobe_mask);
  wire [31:0] next_exception = (exception_register & ~strobe_mask) | (w_data & strobe_mask);
  wire [31:0] next_extension = (extension_register & ~strobe_mask) | (w_data & strobe_mask);
  wire load_source = commit && hit_source;
  wire load_amount = commit && hit_amount;
  wire load_exception = commit && hit_exception;
  wire load_extension = commit && hit_extension;

  // decode of the newly written instruction word
  wire [5:0] primary = next_instruction[shift_right_pkg::primary_hi:shift_right_pkg::primary_lo];
  wire [9:0] ext_code = next_instruction[shift_right_pkg::ext_hi:shift_right_pkg::ext_lo];
  wire record_bit = next_instruction[shift_right_pkg::record_pos];
  shift_right_pkg::op_t op;
  always_comb begin
    op = shift_right_pkg::op_none;
    if (primary == shift_right_pkg::primary_op) begin
      case (ext_code)
        shift_right_pkg::ext_rotate_save: op = shift_right_pkg::op_extension;
        shift_right_pkg::ext_shift_word: op = shift_right_pkg::op_word;
        shift_right_pkg::ext_long_merge: op = shift_right_pkg::op_merge;
        default: op = shift_right_pkg::op_none;
      endcase
    end
  end
  wire execute = commit && hit_instruction;
  wire run = execute && op != shift_right_pkg::op_none;
  wire save_rotated = run && op == shift_right_pkg::op_extension;
  wire record_update = run && record_bit;
  wire [31:0] next_target = (op == shift_right_pkg::op_merge) ? path.merged : path.masked;
  wire negative_flag = next_target[31];
  wire zero_flag = next_target == 32'h0000_0000;
  wire positive_flag = !negative_flag && !zero_flag;
  wire [3:0] next_cond = {negative_flag, positive_flag, zero_flag,
      exception_register[shift_right_pkg::so_pos]};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && !aw_held) begin
      aw_held <= 1'b1;
      aw_addr <= {s_axi_awaddr[7:2], 2'b00};
    end else if (commit) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= shift_right_pkg::reset_word;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && !w_held) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (commit) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= shift_right_pkg::resp_okay;
    end else if (commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= write_mapped ? shift_right_pkg::resp_okay : shift_right_pkg::resp_slverr;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_register <= shift_right_pkg::reset_word;
    end else if (load_source) begin
      source_register <= next_source;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_amount_register <= shift_right_pkg::reset_word;
    end else if (load_amount) begin
      shift_amount_register <= next_amount;
    end
  end

  // only software writes reach the exception register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exception_register <= shift_right_pkg::reset_word;
    end else if (load_exception) begin
      exception_register <= next_exception;
    end
  end

  // all results of one instruction land on the same edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instruction <= shift_right_pkg::reset_word;
      illegal <= 1'b0;
    end else if (execute) begin
      instruction <= next_instruction;
      illegal <= !run;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      target_register <= shift_right_pkg::reset_word;
    end else if (run) begin
      target_register <= next_target;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      extension_register <= shift_right_pkg::reset_word;
    end else if (save_rotated) begin
      extension_register <= path.rotated;
    end else if (load_extension) begin
      extension_register <= next_extension;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cond_field <= 4'h0;
    end else if (record_update) begin
      cond_field <= next_cond;
    end
  end

  // read path: one cycle from address to data
  assign s_axi_arready = !s_axi_rvalid;
  wire [7:0] rd_addr = {s_axi_araddr[7:2], 2'b00};
  logic [31:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_word = shift_right_pkg::reset_word;
    rd_hit = 1'b1;
    case (rd_addr)
      shift_right_pkg::source_off: rd_word = source_register;
      shift_right_pkg::amount_off: rd_word = shift_amount_register;
      shift_right_pkg::extension_off: rd_word = extension_register;
      shift_right_pkg::exception_off: rd_word = exception_register;
      shift_right_pkg::instruction_off: rd_word = instruction;
      shift_right_pkg::target_off: rd_word = target_register;
      shift_right_pkg::status_off: begin
        rd_word[3:0] = cond_field;
        rd_word[shift_right_pkg::illegal_pos] = illegal;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= shift_right_pkg::reset_word;
      s_axi_rresp <= shift_right_pkg::resp_okay;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? shift_right_pkg::resp_okay : shift_right_pkg::resp_slverr;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : shift_right_extension_unit

//--- shift_right_chk.sv
// axi4-lite port assertions for the shift-right unit
`timescale 1ns/1ps
module shift_right_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence wr_answer;
    (!s_axi_awready && !s_axi_wready) ##1 s_axi_bvalid;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (wr_take |=> wr_answer)
    else $error("write answer late");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  chk_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_arready_gate: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready not gated by rvalid");
  chk_unmapped_read: assert property (rd_take and s_axi_araddr > 8'h1b |=>
    s_axi_rresp == shift_right_pkg::resp_slverr) else $error("unmapped read not refused");
  chk_mapped_read: assert property (rd_take and s_axi_araddr < 8'h1c |=>
    s_axi_rresp == shift_right_pkg::resp_okay) else $error("mapped read refused");
  chk_reset_idle: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_bvalid && !s_axi_rvalid) else $error("response during reset");
endmodule : shift_right_chk
bind shift_right_extension_unit shift_right_chk chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

//--- shift_right_extension_unit_bench.sv
// self-checking bench for the shift-right extension unit
`timescale 1ns/1ps
module shift_right_extension_unit_bench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int num_errors = 0, total_checks = 0, cycles = 0;
  shift_right_extension_unit dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  initial forever #10 aclk = ~aclk;
  task test_done;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      test_done;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic ap, wp;
    ap = 1'b1;
    wp = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (ap || wp) begin
      @(posedge aclk);
      if (ap && awready === 1'b1) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && wready === 1'b1) begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    if (er == 2'h0) chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd
  function logic [31:0] op_word(input logic [9:0] e, input logic r);
    return {shift_right_pkg::primary_op, 15'h0, e, r};
  endfunction : op_word
  task run(input logic [31:0] src, amt, ext, ins, tgt, xt, st);
    wr(shift_right_pkg::source_off, src);
    wr(shift_right_pkg::amount_off, amt);
    wr(shift_right_pkg::extension_off, ext);
    wr(shift_right_pkg::instruction_off, ins);
    rd(shift_right_pkg::target_off, tgt);
    rd(shift_right_pkg::extension_off, xt);
    rd(shift_right_pkg::status_off, st);
    $display("test at %0t done", $time);
  endtask : run
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(shift_right_pkg::status_off, 32'h0);
    run(32'h9000300f, 32'h24, 0, op_word(10'h298, 0), 0, 32'hf9000300, 0);
    run(32'hb000300f, 32'h4, 0, op_word(10'h298, 1), 32'h0b000300, 32'hfb000300, 32'h4);
    run(32'hb0043001, 32'h4, 32'h1234, op_word(10'h218, 1), 32'h0b004300, 32'h1234, 32'h4);
    run(32'h9000300f, 32'h24, '1, op_word(10'h2d8, 0), 32'h0fffffff, '1, 32'h4);
    wr(shift_right_pkg::exception_off, 32'h1);
    run(32'hb0043000, 32'h4, '1, op_word(10'h2d8, 1), 32'hfb004300, '1, 32'h9);
    rd(shift_right_pkg::exception_off, 32'h1);
    run(32'hffff, 32'h20, 0, op_word(10'h218, 1), 0, 0, 32'h3);
    run(32'h1, 32'h1, 32'h5, op_word(10'h0, 1), 0, 32'h5, 32'h103);
    wr(shift_right_pkg::target_off, 32'h5a5a);
    rd(shift_right_pkg::target_off, 0);
    wr(8'h40, 32'h1, shift_right_pkg::resp_slverr);
    rd(8'h40, 0, shift_right_pkg::resp_slverr);
    $display("test at %0t done", $time);
    test_done;
  end
endmodule : shift_right_extension_unit_bench
